// [startup_latch.sv]
// pin synchronisers and the snapshot of pin levels taken at start-up
`timescale 1ns/1ns
`default_nettype none
`include "status_pin_consts.svh"

module startup_latch
	import status_pin_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// raw pins
	input wire pin_levels_t pins_in,
	// synchronised levels and snapshot
	output pin_levels_t pins_sync_out,
	output logic [3:0] pin_levels_at_power_up_out,
	output logic snapshot_valid_out
);

	pin_levels_t meta_r;
	pin_levels_t sync_r;
	logic [1:0] fill_r;
	logic [1:0] fill_nxt;
	logic [3:0] snap_r;
	logic [3:0] snap_nxt;
	logic valid_r;
	logic valid_nxt;

	// snapshot waits until the synchroniser holds real pin samples
	always_comb begin
		fill_nxt = fill_r;
		snap_nxt = snap_r;
		valid_nxt = valid_r;
		if (!valid_r) begin
			if (fill_r == `SYNC_FILL) begin
				snap_nxt = {sync_r.output_enable_chip_select_pin,
					sync_r.serial_clock, sync_r.serial_data,
					sync_r.status_pin};
				valid_nxt = 1'b1;
			end else begin
				fill_nxt = fill_r + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			meta_r <= '0;
			sync_r <= '0;
			fill_r <= 2'h0;
			snap_r <= 4'h0;
			valid_r <= 1'b0;
		end else begin
			meta_r <= pins_in;
			sync_r <= meta_r;
			fill_r <= fill_nxt;
			snap_r <= snap_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign pins_sync_out = sync_r;
	assign pin_levels_at_power_up_out = snap_r;
	assign snapshot_valid_out = valid_r;

endmodule
`default_nettype wire

// [status_pin_board.sv]
// board side of the status pin: external pull-up plus the device pulls
`timescale 1ns/1ns
`default_nettype none

module status_pin_board (
	// device drivers
	input wire logic drv_in,
	input wire logic oe_in,
	input wire logic pu_in,
	input wire logic pd_in,
	// resolved wire level
	output logic level_out
);
	// a released pin floats to the board pull-up unless only pull-down is on
	always_comb begin
		if (oe_in) begin
			level_out = drv_in;
		end else if (pd_in && !pu_in) begin
			level_out = 1'b0;
		end else begin
			level_out = 1'b1;
		end
	end
endmodule

`default_nettype wire

// [status_pin_consts.svh]
// register offsets, field positions, reset values and write masks
`ifndef STATUS_PIN_CONSTS_SVH
`define STATUS_PIN_CONSTS_SVH

`define ADDR_PIN_CFG 3'h0
`define ADDR_SNAPSHOT 3'h1
`define ADDR_LIVE 3'h2
`define ADDR_SCRATCH 3'h3
`define ADDR_DRIVE_CFG 3'h4

`define CFG_OD_BIT 12
`define CFG_HIZ_BIT 11
`define CFG_PD_BIT 10
`define CFG_PU_BIT 9
`define CFG_POL_BIT 8
`define CFG_SEL_MSB 4
`define CFG_RESET 16'h0200
`define CFG_WMASK 16'h1f1f

`define SNAP_DIE_BIT 7

`define LIVE_OUT_BIT 1
`define LIVE_OE_BIT 0

`define DRV_OESEL_BIT 0
`define DRV_OEPOL_BIT 1
`define DRV_OD_MSB 3
`define DRV_OD_LSB 2
`define DRV_RESET 8'h0c
`define DRV_WMASK 8'h0f

`define SCRATCH_RESET 32'h00000000

`define SEL_LAST_LIVE 5'h04
`define SYNC_FILL 2'h2

`endif

// [status_pin_output_control.sv]
// status pin output control with its configuration and status registers
`timescale 1ns/1ns
`default_nettype none
`include "status_pin_consts.svh"

module status_pin_output_control
	import status_pin_pkg::*;
#(
	parameter int INT_W = 8
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// register port
	input wire reg_req_t reg_req_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// internal conditions
	input wire status_sources_t src_in,
	input wire logic [INT_W-1:0] int_sts_in,
	input wire logic [INT_W-1:0] int_en_in,
	// pins sampled from outside
	input wire pin_levels_t pins_in,
	// status pin driver
	output logic status_pin_out,
	output logic status_pin_oe_out,
	output logic status_pin_pullup_en_out,
	output logic status_pin_pulldown_en_out,
	output logic [1:0] open_drain_strength_out,
	// clock output driver gate
	output logic clk_drivers_en_out
);

	initial begin
		if (INT_W < 1 || INT_W > 32) begin
			$error("INT_W must lie between 1 and 32");
		end
	end

	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [7:0] drv_r;
	logic [7:0] drv_nxt;
	logic [31:0] scratch_r;
	logic [31:0] scratch_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic pin_r;
	logic pin_nxt;
	logic oe_r;
	logic oe_nxt;
	logic level_r;
	logic level_nxt;
	logic pu_r;
	logic pu_nxt;
	logic pd_r;
	logic pd_nxt;
	logic [1:0] strength_r;
	logic [1:0] strength_nxt;
	logic clk_en_r;
	logic clk_en_nxt;
	logic [4:0] sel;
	logic pol_eff;
	logic src_level;
	logic drive_level;
	pin_levels_t pins_sync;
	logic [3:0] power_up_levels;
	logic snapshot_valid;

	startup_latch u_startup (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.pins_in(pins_in),
		.pins_sync_out(pins_sync),
		.pin_levels_at_power_up_out(power_up_levels),
		.snapshot_valid_out(snapshot_valid)
	);

	assign sel = cfg_r[`CFG_SEL_MSB:0];

	status_source_mux #(
		.INT_W(INT_W)
	) u_mux (
		.sel_in(sel),
		.src_in(src_in),
		.int_sts_in(int_sts_in),
		.int_en_in(int_en_in),
		.level_out(src_level)
	);

	function automatic logic [31:0] read_word(input logic [2:0] addr,
		input logic [15:0] cfg, input logic [7:0] drv,
		input logic [31:0] scr, input logic [7:0] snap,
		input logic [7:0] live);
		case (addr)
			`ADDR_PIN_CFG: read_word = {16'h0000, cfg};
			`ADDR_SNAPSHOT: read_word = {24'h000000, snap};
			`ADDR_LIVE: read_word = {24'h000000, live};
			`ADDR_SCRATCH: read_word = scr;
			`ADDR_DRIVE_CFG: read_word = {24'h000000, drv};
			default: read_word = 32'h00000000;
		endcase
	endfunction

	// register writes and reads
	always_comb begin
		logic [7:0] snap;
		logic [7:0] live;
		snap = 8'h00;
		live = 8'h00;
		cfg_nxt = cfg_r;
		drv_nxt = drv_r;
		scratch_nxt = scratch_r;
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				`ADDR_PIN_CFG: cfg_nxt = reg_req_in.wdata[15:0] & `CFG_WMASK;
				`ADDR_SCRATCH: scratch_nxt = reg_req_in.wdata;
				`ADDR_DRIVE_CFG: drv_nxt = reg_req_in.wdata[7:0] & `DRV_WMASK;
				default: scratch_nxt = scratch_r;
			endcase
		end
		snap[3:0] = power_up_levels;
		snap[`SNAP_DIE_BIT] = pins_sync.die_option_pad_value;
		live[`LIVE_OUT_BIT] = (sel <= `SEL_LAST_LIVE) ? level_r : 1'b0;
		live[`LIVE_OE_BIT] = drv_r[`DRV_OESEL_BIT] ? 1'b0 :
			pins_sync.output_enable_chip_select_pin;
		rvalid_nxt = reg_req_in.rd;
		rdata_nxt = reg_req_in.rd ?
			read_word(reg_req_in.addr, cfg_r, drv_r, scratch_r, snap, live) :
			rdata_r;
	end

	// pin driver
	always_comb begin
		pol_eff = cfg_r[`CFG_POL_BIT] && (sel != SEL_NO_POLARITY);
		drive_level = src_level ^ pol_eff;
		level_nxt = drive_level;
		if (cfg_r[`CFG_HIZ_BIT]) begin
			pin_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else if (cfg_r[`CFG_OD_BIT]) begin
			pin_nxt = 1'b0;
			oe_nxt = ~drive_level;
		end else begin
			pin_nxt = drive_level;
			oe_nxt = 1'b1;
		end
		pu_nxt = cfg_r[`CFG_PU_BIT];
		pd_nxt = cfg_r[`CFG_PD_BIT];
		strength_nxt = drv_r[`DRV_OD_MSB:`DRV_OD_LSB];
		clk_en_nxt = drv_r[`DRV_OESEL_BIT] ? 1'b1 :
			(pins_sync.output_enable_chip_select_pin ^
			drv_r[`DRV_OEPOL_BIT]);
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cfg_r <= `CFG_RESET;
			drv_r <= `DRV_RESET;
			scratch_r <= `SCRATCH_RESET;
			rdata_r <= 32'h00000000;
			rvalid_r <= 1'b0;
			pin_r <= 1'b0;
			oe_r <= 1'b0;
			level_r <= 1'b0;
			pu_r <= 1'b1;
			pd_r <= 1'b0;
			strength_r <= 2'h3;
			clk_en_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			drv_r <= drv_nxt;
			scratch_r <= scratch_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			pin_r <= pin_nxt;
			oe_r <= oe_nxt;
			level_r <= level_nxt;
			pu_r <= pu_nxt;
			pd_r <= pd_nxt;
			strength_r <= strength_nxt;
			clk_en_r <= clk_en_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;
	assign reg_rvalid_out = rvalid_r;
	assign status_pin_out = pin_r;
	assign status_pin_oe_out = oe_r;
	assign status_pin_pullup_en_out = pu_r;
	assign status_pin_pulldown_en_out = pd_r;
	assign open_drain_strength_out = strength_r;
	assign clk_drivers_en_out = clk_en_r;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	od_true_pol_a: assert property (
		!cfg_r[`CFG_HIZ_BIT] && cfg_r[`CFG_OD_BIT] && !pol_eff
		|=> (status_pin_oe_out == !$past(src_level)) && !status_pin_out)
		else $error("open-drain true polarity drive wrong");
	od_inv_pol_a: assert property (
		!cfg_r[`CFG_HIZ_BIT] && cfg_r[`CFG_OD_BIT] && pol_eff
		|=> (status_pin_oe_out == $past(src_level)) && !status_pin_out)
		else $error("open-drain inverted drive wrong");
	tristate_pin_a: assert property (
		cfg_r[`CFG_HIZ_BIT] |=> !status_pin_oe_out)
		else $error("status pin driven while tristated");
	pulls_follow_a: assert property (
		$changed(cfg_r[`CFG_PD_BIT])
		|=> status_pin_pulldown_en_out == $past(cfg_r[`CFG_PD_BIT]))
		else $error("pull-down enable not applied");
	pullup_reset_a: assert property (
		$fell(rst_in) |-> status_pin_pullup_en_out)
		else $error("pull-up not on after reset");
	pushpull_pol_a: assert property (
		!cfg_r[`CFG_HIZ_BIT] && !cfg_r[`CFG_OD_BIT]
		|=> status_pin_oe_out &&
		status_pin_out == ($past(src_level) ^ $past(pol_eff)))
		else $error("push-pull level wrong");
	nopol_code_a: assert property (
		sel == SEL_NO_POLARITY |-> !pol_eff)
		else $error("polarity applied on code 0x1F");
	dev_int_a: assert property (
		sel == SEL_DEV_INT |-> src_level == |(int_sts_in & int_en_in))
		else $error("device interrupt level wrong");
	force_high_a: assert property (
		sel == SEL_FORCE_HIGH && !cfg_r[`CFG_POL_BIT] && !cfg_r[`CFG_HIZ_BIT]
		&& !cfg_r[`CFG_OD_BIT] ##1 sel == SEL_FORCE_HIGH |-> status_pin_out)
		else $error("forced high not driven");
	snapshot_hold_a: assert property (
		snapshot_valid |=> $stable(power_up_levels))
		else $error("start-up snapshot changed");
	scratch_back_a: assert property (
		reg_req_in.wr && reg_req_in.addr == `ADDR_SCRATCH
		##1 reg_req_in.rd && reg_req_in.addr == `ADDR_SCRATCH && !reg_req_in.wr
		|=> reg_rdata_out == $past(reg_req_in.wdata, 2))
		else $error("scratch readback mismatch");
	clk_gate_a: assert property (
		drv_r[`DRV_OESEL_BIT] |=> clk_drivers_en_out)
		else $error("enable pin gated drivers while ignored");
	strength_a: assert property (
		$fell(rst_in) |-> open_drain_strength_out == 2'h3)
		else $error("open-drain strength reset wrong");

	od_mode_c: cover property (cfg_r[`CFG_OD_BIT] && !status_pin_oe_out);
	tristate_c: cover property (cfg_r[`CFG_HIZ_BIT] ##1 !status_pin_oe_out);
	dev_int_c: cover property (sel == SEL_DEV_INT && src_level);
	scratch_c: cover property (reg_req_in.wr &&
		reg_req_in.addr == `ADDR_SCRATCH);

endmodule
`default_nettype wire

// [status_pin_pkg.sv]
// types shared by the status pin block
package status_pin_pkg;

	typedef enum logic [4:0] {
		SEL_PLL_LOCK = 5'h00,
		SEL_REF0_LOS = 5'h02,
		SEL_XTAL_LOS = 5'h04,
		SEL_REF0_ACT = 5'h05,
		SEL_REF0_INVALID = 5'h07,
		SEL_DEV_INT = 5'h09,
		SEL_DEV_READY = 5'h0a,
		SEL_FORCE_LOW = 5'h1d,
		SEL_FORCE_HIGH = 5'h1e,
		SEL_NO_POLARITY = 5'h1f
	} sel_code_t;

	typedef struct packed {
		logic pll_lock;
		logic ref0_los;
		logic xtal_los;
		logic ref0_act;
		logic ref0_invalid;
		logic dev_ready;
	} status_sources_t;

	typedef struct packed {
		logic [2:0] addr;
		logic wr;
		logic rd;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic status_pin;
		logic serial_data;
		logic serial_clock;
		logic output_enable_chip_select_pin;
		logic die_option_pad_value;
	} pin_levels_t;

endpackage

// [status_source_mux.sv]
// picks the internal condition shown on the status pin
`timescale 1ns/1ns
`default_nettype none

module status_source_mux
	import status_pin_pkg::*;
#(
	parameter int INT_W = 8
) (
	// selection
	input wire logic [4:0] sel_in,
	// conditions
	input wire status_sources_t src_in,
	input wire logic [INT_W-1:0] int_sts_in,
	input wire logic [INT_W-1:0] int_en_in,
	// chosen level
	output logic level_out
);

	initial begin
		if (INT_W < 1) begin
			$error("INT_W must be at least 1");
		end
	end

	always_comb begin
		unique case (sel_in)
			SEL_PLL_LOCK: level_out = src_in.pll_lock;
			SEL_REF0_LOS: level_out = src_in.ref0_los;
			SEL_XTAL_LOS: level_out = src_in.xtal_los;
			SEL_REF0_ACT: level_out = src_in.ref0_act;
			SEL_REF0_INVALID: level_out = src_in.ref0_invalid;
			SEL_DEV_INT: level_out = |(int_sts_in & int_en_in);
			SEL_DEV_READY: level_out = src_in.dev_ready;
			SEL_FORCE_LOW: level_out = 1'b0;
			SEL_FORCE_HIGH: level_out = 1'b1;
			// reserved codes show a quiet low
			default: level_out = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the status pin output control block
`timescale 1ns/1ns
`default_nettype none
`include "status_pin_consts.svh"

module tb;
	import status_pin_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	reg_req_t req = '0;
	logic [31:0] rdata;
	logic rvalid, pin_o, pin_oe, pu, pd, clk_en, wire_lvl;
	logic [1:0] strength;
	status_sources_t src = '0;
	logic [7:0] sts = '0;
	logic [7:0] en = '0;
	logic sda = 1'b0, scl = 1'b1, oe_pin = 1'b1, die = 1'b1;
	pin_levels_t pins;
	int err_total = 0;
	int checked = 0;
	logic [31:0] seed = 32'h0000002d;

	assign pins = '{wire_lvl, sda, scl, oe_pin, die};

	status_pin_output_control #(.INT_W(8)) i_dut (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_req_in(req),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .src_in(src),
		.int_sts_in(sts), .int_en_in(en), .pins_in(pins),
		.status_pin_out(pin_o), .status_pin_oe_out(pin_oe),
		.status_pin_pullup_en_out(pu), .status_pin_pulldown_en_out(pd),
		.open_drain_strength_out(strength), .clk_drivers_en_out(clk_en));

	status_pin_board i_board (.drv_in(pin_o), .oe_in(pin_oe), .pu_in(pu),
		.pd_in(pd), .level_out(wire_lvl));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic lvl(logic [4:0] s, logic pol);
		logic m;
		case (s)
			5'h00: m = src.pll_lock;
			5'h02: m = src.ref0_los;
			5'h04: m = src.xtal_los;
			5'h05: m = src.ref0_act;
			5'h07: m = src.ref0_invalid;
			5'h09: m = |(sts & en);
			5'h0a: m = src.dev_ready;
			5'h1e: m = 1'b1;
			default: m = 1'b0;
		endcase
		return m ^ (pol && s != 5'h1f);
	endfunction

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic wr(logic [2:0] a, logic [31:0] d);
		// let one edge pass so a previous strobe is never re-raised at once
		@(negedge clk_sys_in);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge clk_sys_in);
		req.wr = 1'b0;
	endtask

	// read and compare; rvalid must come within a few cycles
	task automatic rd(logic [2:0] a, logic [31:0] e);
		int n;
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk_sys_in);
		req.rd = 1'b0;
		n = 0;
		while (rvalid !== 1'b1 && n < 4) begin
			@(negedge clk_sys_in);
			n++;
		end
		if (n == 4) begin
			err_total++;
			end_sim();
		end else begin
			chk(rdata, e);
		end
		@(negedge clk_sys_in);
	endtask

	task automatic pin_case(logic [4:0] s, logic pol, logic od, logic hiz);
		logic l;
		wr(`ADDR_PIN_CFG, {19'h0, od, hiz, 2'b01, pol, 3'h0, s});
		repeat (2) @(negedge clk_sys_in);
		l = lvl(s, pol);
		chk({pin_oe, pin_o}, hiz ? 2'b00 : od ? {~l, 1'b0} : {1'b1, l});
		chk(wire_lvl, hiz ? 1'b1 : l);
		rd(`ADDR_LIVE, {30'h0, s <= 5'h04 ? l : 1'b0, oe_pin});
	endtask

	initial begin
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	initial begin
		repeat (5000) @(negedge clk_sys_in);
		err_total++;
		end_sim();
	end

	initial begin
		logic [4:0] codes [10];
		logic [31:0] v;
		logic sel, pol;
		codes = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h1d,
			5'h1e, 5'h1f};
		repeat (12) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		chk({pu, pd, strength}, 4'hb);
		rd(`ADDR_PIN_CFG, 32'h00000200);
		rd(`ADDR_DRIVE_CFG, 32'h0000000c);
		rd(`ADDR_SNAPSHOT, {24'h0, die, 3'h0, oe_pin, scl, sda, 1'b1});
		wr(`ADDR_SNAPSHOT, 32'h0);
		rd(`ADDR_SNAPSHOT, {24'h0, die, 3'h0, oe_pin, scl, sda, 1'b1});
		rd(3'h7, 32'h0);
		wr(`ADDR_PIN_CFG, 32'hffffffff);
		rd(`ADDR_PIN_CFG, 32'h00001f1f);
		$display("reset and register test done");
		rd(`ADDR_SCRATCH, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			wr(`ADDR_SCRATCH, v);
			rd(`ADDR_SCRATCH, v);
		end
		$display("scratch test done");
		src = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		pin_case(5'h00, 1'b1, 1'b0, 1'b0);
		pin_case(5'h1f, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 20; i++) begin
			v = rnd();
			src = v[5:0];
			sts = v[13:6];
			en = v[21:14];
			pin_case(codes[i % 10], v[22], v[23], v[24] & v[25]);
		end
		$display("selector test done");
		wr(`ADDR_PIN_CFG, 32'h0000041d);
		for (int k = 0; k < 4; k++) begin
			v = rnd();
			sel = k[0];
			pol = k[1];
			oe_pin = v[0];
			wr(`ADDR_DRIVE_CFG, {28'h0, 2'b11, pol, sel});
			repeat (4) @(negedge clk_sys_in);
			chk(clk_en, sel ? 1'b1 : oe_pin ^ pol);
			rd(`ADDR_LIVE, {31'h0, sel ? 1'b0 : oe_pin});
		end
		chk({pu, pd}, 2'b01);
		$display("enable pin test done");
		end_sim();
	end
endmodule

`default_nettype wire
